// File: src/led_cfg.svh
// timing and pattern constants for the status indicator encoder
`ifndef LED_CFG_SVH
`define LED_CFG_SVH

// clock period and one millisecond, both in picoseconds
`define CLK_PERIOD_PS   32'h00001F40
`define MS_PS           32'h3B9ACA00
`define MS_CYCLES_DEF   (`MS_PS / `CLK_PERIOD_PS)

// on/off durations in milliseconds
`define BLINK_ON_MS     16'h00C8
`define BLINK_OFF_MS    16'h00C8
`define FLASH_ON_MS     16'h00C8
`define FLASH_GAP_MS    16'h03E8
`define DFLASH_OFF_MS   16'h00C8
`define FLICK_MS        16'h0032
`define ALARM_ON_MS     16'h00C8
`define ALARM_OFF_MS    16'h00C8
`define ALARM_GAP_MS    16'h05DC
`define SIM_STEP_MS     16'h01F4

// pulse counts per group
`define ONE_PULSE       8'h01
`define TWO_PULSES      8'h02

`endif

// File: src/led_pkg.sv
// types shared by the status indicator encoder modules
package led_pkg;

  typedef enum logic [1:0] {
    PAT_ON  = 2'h0,
    PAT_OFF = 2'h1,
    PAT_GAP = 2'h3
  } pat_state_t;

  typedef enum logic [2:0] {
    PA_DARK    = 3'h0,
    PA_GREEN   = 3'h1,
    PA_INFO    = 3'h3,
    PA_ILOCK   = 3'h2,
    PA_EXEC    = 3'h6,
    PA_REMOVAL = 3'h7,
    PA_ALARM   = 3'h5,
    PA_SIM     = 3'h4
  } pa_mode_t;

  typedef enum logic [1:0] {
    SIM_GREEN = 2'h0,
    SIM_RED   = 2'h1,
    SIM_BOTH  = 2'h3,
    SIM_DARK  = 2'h2
  } sim_step_t;

  typedef enum logic [1:0] {
    FB_INIT   = 2'h0,
    FB_PREOP  = 2'h1,
    FB_SAFEOP = 2'h2,
    FB_OP     = 2'h3
  } fb_state_t;

  typedef enum logic [1:0] {
    ERR_NONE  = 2'h0,
    ERR_SETUP = 2'h1,
    ERR_DATA  = 2'h2,
    ERR_WDOG  = 2'h3
  } comm_err_t;

endpackage

// File: src/ms_timebase.sv
// one-cycle tick every millisecond
`timescale 1ns/100ps
`include "led_cfg.svh"
module ms_timebase #(
  parameter int unsigned CYC = `MS_CYCLES_DEF
) (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic ce,
  // tick out
  output logic      tick_r
);

  localparam int unsigned W = $clog2(CYC);

  logic [W-1:0] cnt_r;
  logic         wrap;

  assign wrap = (cnt_r == W'(CYC - 1));

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_r  <= '0;
      tick_r <= 1'b0;
    end
    else if (ce)
    begin
      cnt_r  <= wrap ? '0 : W'(cnt_r + 1'b1);
      tick_r <= wrap;
    end
  end

endmodule

// File: src/pattern_gen.sv
// on/off pulse group generator: pulses on/off, then a long gap
`timescale 1ns/100ps
`include "led_cfg.svh"
module pattern_gen
  import led_pkg::*;
#(
  parameter logic [15:0] ON_MS  = `BLINK_ON_MS,
  parameter logic [15:0] OFF_MS = `BLINK_OFF_MS,
  parameter logic [15:0] GAP_MS = `BLINK_OFF_MS
) (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  // timing and control
  input  wire logic       tick,
  input  wire logic       enable,
  input  wire logic [7:0] pulses,
  // pattern level
  output logic            lit
);

  pat_state_t  st_r;
  logic [15:0] cnt_r;
  logic [7:0]  pulse_r;
  logic [15:0] limit;
  logic        done;
  logic        last_pulse;

  always_comb
  begin
    case (st_r)
      PAT_ON:  limit = ON_MS;
      PAT_OFF: limit = OFF_MS;
      default: limit = GAP_MS;
    endcase
  end

  assign done       = (16'(cnt_r + 16'h0001) >= limit);
  // a count of zero still gives one pulse per group
  assign last_pulse = (8'(pulse_r + 8'h01) >= pulses);
  assign lit        = enable && (st_r == PAT_ON);

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r    <= PAT_ON;
      cnt_r   <= 16'h0000;
      pulse_r <= 8'h00;
    end
    else if (ce)
    begin
      // restart so each group begins with a whole pulse
      if (!enable)
      begin
        st_r    <= PAT_ON;
        cnt_r   <= 16'h0000;
        pulse_r <= 8'h00;
      end
      else if (tick)
      begin
        if (done)
        begin
          cnt_r <= 16'h0000;
          case (st_r)
            PAT_ON:
            begin
              if (last_pulse)
              begin
                st_r    <= PAT_GAP;
                pulse_r <= 8'h00;
              end
              else
              begin
                st_r    <= PAT_OFF;
                pulse_r <= 8'(pulse_r + 8'h01);
              end
            end
            PAT_OFF: st_r <= PAT_ON;
            default: st_r <= PAT_ON;
          endcase
        end
        else
        begin
          cnt_r <= 16'(cnt_r + 16'h0001);
        end
      end
    end
  end

endmodule

// File: src/drive_status_led_encoder.sv
// front-panel status indicator encoder of the motor driver
`timescale 1ns/100ps
`include "led_cfg.svh"

// Functional notes
// - no control power: green and red dark
// - power, nothing special: steady green only
// - alarm: red blinks code count, green off
// - removal: blink green until clear input after release
// - info or remote: double-blink both colours
// - interlock release: blink both for set duration
// - preset function running: both steadily lit
// - simulation: green, red, both, dark repeating
// - run indicator follows fieldbus state
// - error indicator shows communication error class
// - link indicator: dark, lit, flicker on traffic
module drive_status_led_encoder
  import led_pkg::*;
#(
  parameter int unsigned MS_CYCLES = `MS_CYCLES_DEF
) (
  // clock, enable and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // power and alarm conditions
  input  wire logic        ctrl_power_ok,
  input  wire logic        alarm_active,
  input  wire logic [7:0]  alarm_blinks,
  input  wire logic        removal_active,
  input  wire logic        removal_clear_input,
  input  wire logic        info_active,
  input  wire logic        remote_active,
  input  wire logic        ilock_release,
  input  wire logic [15:0] ilock_ms,
  input  wire logic        preset_exec,
  input  wire logic        sim_mode,
  // fieldbus status
  input  wire fb_state_t   fb_state,
  input  wire comm_err_t   comm_err,
  input  wire logic        link_up,
  input  wire logic        link_traffic,
  // indicator drives
  output logic             pa_green_r,
  output logic             pa_red_r,
  output logic             run_led_r,
  output logic             err_led_r,
  output logic             link_led_r
);

  function automatic sim_step_t next_step(input sim_step_t s);
    case (s)
      SIM_GREEN: next_step = SIM_RED;
      SIM_RED:   next_step = SIM_BOTH;
      SIM_BOTH:  next_step = SIM_DARK;
      default:   next_step = SIM_GREEN;
    endcase
  endfunction

  logic        pwr_meta_r;
  logic        pwr_s_r;
  logic        tick;
  logic        blink_lit;
  logic        sflash_lit;
  logic        dflash_lit;
  logic        flick_lit;
  logic        alarm_lit;
  logic        removal_hold_r;
  logic [15:0] ilock_left_r;
  logic [15:0] sim_cnt_r;
  logic        sim_adv;
  sim_step_t   sim_step_r;
  pa_mode_t    pa_mode_r;
  pa_mode_t    pa_mode_nxt;

  // power sense arrives from a supply monitor pin
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pwr_meta_r <= 1'b0;
      pwr_s_r    <= 1'b0;
    end
    else if (ce)
    begin
      pwr_meta_r <= ctrl_power_ok;
      pwr_s_r    <= pwr_meta_r;
    end
  end

  ms_timebase #(
    .CYC (MS_CYCLES)
  ) u_tb (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .ce     (ce),
    .tick_r (tick)
  );

  pattern_gen #(
    .ON_MS  (`BLINK_ON_MS),
    .OFF_MS (`BLINK_OFF_MS),
    .GAP_MS (`BLINK_OFF_MS)
  ) u_blink (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .ce     (ce),
    .tick   (tick),
    .enable (1'b1),
    .pulses (`ONE_PULSE),
    .lit    (blink_lit)
  );

  pattern_gen #(
    .ON_MS  (`FLASH_ON_MS),
    .OFF_MS (`FLASH_GAP_MS),
    .GAP_MS (`FLASH_GAP_MS)
  ) u_sflash (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .ce     (ce),
    .tick   (tick),
    .enable (1'b1),
    .pulses (`ONE_PULSE),
    .lit    (sflash_lit)
  );

  pattern_gen #(
    .ON_MS  (`FLASH_ON_MS),
    .OFF_MS (`DFLASH_OFF_MS),
    .GAP_MS (`FLASH_GAP_MS)
  ) u_dflash (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .ce     (ce),
    .tick   (tick),
    .enable (1'b1),
    .pulses (`TWO_PULSES),
    .lit    (dflash_lit)
  );

  pattern_gen #(
    .ON_MS  (`FLICK_MS),
    .OFF_MS (`FLICK_MS),
    .GAP_MS (`FLICK_MS)
  ) u_flick (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .ce     (ce),
    .tick   (tick),
    .enable (link_traffic),
    .pulses (`ONE_PULSE),
    .lit    (flick_lit)
  );

  // group length is the alarm's blink count
  pattern_gen #(
    .ON_MS  (`ALARM_ON_MS),
    .OFF_MS (`ALARM_OFF_MS),
    .GAP_MS (`ALARM_GAP_MS)
  ) u_alarm (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .ce     (ce),
    .tick   (tick),
    .enable (pa_mode_r == PA_ALARM),
    .pulses (alarm_blinks),
    .lit    (alarm_lit)
  );

  // hold until clear input; a new removal wins over clear
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      removal_hold_r <= 1'b0;
    else if (ce)
    begin
      if (removal_active)
        removal_hold_r <= 1'b1;
      else if (removal_clear_input)
        removal_hold_r <= 1'b0;
    end
  end

  // load on release, count down in milliseconds
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      ilock_left_r <= 16'h0000;
    else if (ce)
    begin
      if (ilock_release)
        ilock_left_r <= ilock_ms;
      else if (tick && (ilock_left_r != 16'h0000))
        ilock_left_r <= 16'(ilock_left_r - 16'h0001);
    end
  end

  assign sim_adv = (pa_mode_r == PA_SIM) && tick &&
                   (16'(sim_cnt_r + 16'h0001) >= `SIM_STEP_MS);

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sim_cnt_r  <= 16'h0000;
      sim_step_r <= SIM_GREEN;
    end
    else if (ce)
    begin
      if (pa_mode_r != PA_SIM)
      begin
        sim_cnt_r  <= 16'h0000;
        sim_step_r <= SIM_GREEN;
      end
      else if (sim_adv)
      begin
        sim_cnt_r  <= 16'h0000;
        sim_step_r <= next_step(sim_step_r);
      end
      else if (tick)
        sim_cnt_r <= 16'(sim_cnt_r + 16'h0001);
    end
  end

  always_comb
  begin
    if (!pwr_s_r)
      pa_mode_nxt = PA_DARK;
    else if (alarm_active)
      pa_mode_nxt = PA_ALARM;
    else if (removal_hold_r || removal_active)
      pa_mode_nxt = PA_REMOVAL;
    else if (sim_mode)
      pa_mode_nxt = PA_SIM;
    else if (preset_exec)
      pa_mode_nxt = PA_EXEC;
    else if (ilock_left_r != 16'h0000)
      pa_mode_nxt = PA_ILOCK;
    else if (info_active || remote_active)
      pa_mode_nxt = PA_INFO;
    else
      pa_mode_nxt = PA_GREEN;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      pa_mode_r <= PA_DARK;
    else if (ce)
      pa_mode_r <= pa_mode_nxt;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pa_green_r <= 1'b0;
      pa_red_r   <= 1'b0;
    end
    else if (ce)
    begin
      case (pa_mode_r)
        PA_DARK:
        begin
          pa_green_r <= 1'b0;
          pa_red_r   <= 1'b0;
        end
        PA_ALARM:
        begin
          pa_green_r <= 1'b0;
          pa_red_r   <= alarm_lit;
        end
        PA_REMOVAL:
        begin
          pa_green_r <= blink_lit;
          pa_red_r   <= 1'b0;
        end
        PA_SIM:
        begin
          pa_green_r <= (sim_step_r == SIM_GREEN) ||
                        (sim_step_r == SIM_BOTH);
          pa_red_r   <= (sim_step_r == SIM_RED) ||
                        (sim_step_r == SIM_BOTH);
        end
        PA_EXEC:
        begin
          pa_green_r <= 1'b1;
          pa_red_r   <= 1'b1;
        end
        PA_ILOCK:
        begin
          pa_green_r <= blink_lit;
          pa_red_r   <= blink_lit;
        end
        PA_INFO:
        begin
          pa_green_r <= dflash_lit;
          pa_red_r   <= dflash_lit;
        end
        default:
        begin
          pa_green_r <= 1'b1;
          pa_red_r   <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      run_led_r <= 1'b0;
    else if (ce)
    begin
      case (fb_state)
        FB_PREOP:  run_led_r <= blink_lit;
        FB_SAFEOP: run_led_r <= sflash_lit;
        FB_OP:     run_led_r <= 1'b1;
        default:   run_led_r <= 1'b0;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      err_led_r <= 1'b0;
    else if (ce)
    begin
      case (comm_err)
        ERR_SETUP: err_led_r <= blink_lit;
        ERR_DATA:  err_led_r <= sflash_lit;
        ERR_WDOG:  err_led_r <= dflash_lit;
        default:   err_led_r <= 1'b0;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      link_led_r <= 1'b0;
    else if (ce)
      link_led_r <= link_up && (!link_traffic || flick_lit);
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  chk_dark_no_power: assert property (
    (ce && pa_mode_r == PA_DARK) |=> (!pa_green_r && !pa_red_r))
    else $error("indicator lit without control power");
  chk_steady_green: assert property (
    (ce && pa_mode_r == PA_GREEN) |=> (pa_green_r && !pa_red_r))
    else $error("idle indicator not steady green");
  chk_alarm_red_blink: assert property (
    (ce && pa_mode_r == PA_ALARM)
      |=> (!pa_green_r && pa_red_r == $past(alarm_lit)))
    else $error("alarm pattern wrong");
  chk_removal_hold: assert property (
    (ce && removal_hold_r && !removal_clear_input)
      |=> removal_hold_r)
    else $error("removal hold dropped without clear");
  chk_info_double: assert property (
    (ce && pa_mode_r == PA_INFO)
      |=> (pa_green_r == $past(dflash_lit) && pa_red_r == pa_green_r))
    else $error("information pattern wrong");
  chk_ilock_countdown: assert property (
    (ce && !ilock_release && tick && ilock_left_r != 16'h0000)
      |=> (ilock_left_r == 16'($past(ilock_left_r) - 16'h0001)))
    else $error("interlock countdown wrong");
  chk_exec_both_lit: assert property (
    (ce && pa_mode_r == PA_EXEC) |=> (pa_green_r && pa_red_r))
    else $error("preset execution not both lit");
  chk_sim_sequence: assert property (
    (ce && sim_adv) |=> (sim_step_r == next_step($past(sim_step_r))))
    else $error("simulation sequence out of order");
  chk_run_operational: assert property (
    (ce && fb_state == FB_OP) |=> run_led_r)
    else $error("run indicator dark in operational");
  chk_err_quiet: assert property (
    (ce && comm_err == ERR_NONE) |=> !err_led_r)
    else $error("error indicator lit with no error");
  chk_link_dark: assert property (
    (ce && !link_up) |=> !link_led_r)
    else $error("link indicator lit without link");
  chk_alarm_priority: assert property (
    (ce && pwr_s_r && alarm_active) |=> (pa_mode_r == PA_ALARM))
    else $error("alarm lost priority");

  cov_alarm_shown: cover property (ce && pa_mode_r == PA_ALARM && pa_red_r);
  cov_sim_wrap: cover property (sim_adv && sim_step_r == SIM_DARK);
  cov_ilock_expire: cover property (
    ce && pa_mode_r == PA_ILOCK ##1 pa_mode_r == PA_GREEN);
  cov_removal_held: cover property (
    removal_hold_r && !removal_active && pa_mode_r == PA_REMOVAL);

endmodule

// File: bench/panel_viewer.sv
// operator view of the five indicators: lit time and longest lit run
`timescale 1ns/100ps
module panel_viewer (
  // clock and window restart
  input  wire logic             mclk,
  input  wire logic             clr,
  // indicator lines, high = lit
  input  wire logic [4:0]       leds,
  // per indicator statistics
  output logic      [4:0][15:0] lit_cnt,
  output logic      [4:0][15:0] run_max,
  output logic      [4:0]       unk
);
  logic [4:0][15:0] run_r;

  // an undriven line is flagged and ends the lit run as dark does, never counted as lit
  always_ff @(posedge mclk)
  begin
    for (int i = 0; i < 5; i++)
    begin
      if (clr)
      begin
        lit_cnt[i] <= 16'h0000;
        run_max[i] <= 16'h0000;
        run_r[i]   <= 16'h0000;
        unk[i]     <= 1'b0;
      end
      else if (leds[i] === 1'b1)
      begin
        lit_cnt[i] <= lit_cnt[i] + 16'h0001;
        run_r[i]   <= run_r[i] + 16'h0001;
        if (run_r[i] + 16'h0001 > run_max[i])
          run_max[i] <= run_r[i] + 16'h0001;
      end
      else
      begin
        run_r[i] <= 16'h0000;
        if (leds[i] !== 1'b0)
          unk[i] <= 1'b1;
      end
    end
  end
endmodule

// File: bench/drive_status_led_encoder_tb.sv
// self-checking bench of the status indicator encoder
`timescale 1ns/100ps
`include "led_cfg.svh"
module drive_status_led_encoder_tb import led_pkg::*;;
  // 1 ms shortened to 4 cycles; all windows except the fixed 400-cycle ones and the 3000-cycle freeze scale with it
  localparam int MS   = 4;
  localparam int ON   = `BLINK_ON_MS * MS;
  localparam int STEP = `SIM_STEP_MS * MS;
  localparam int W    = 2 * (`FLASH_ON_MS + `FLASH_GAP_MS) * MS;

  logic             mclk = 1'b0;
  logic             rst_n = 1'b0;
  logic             ce = 1'b1;
  logic [12:0]      st = 13'h1000;
  logic             clr_in = 1'b0;
  logic             ilk = 1'b0;
  logic [15:0]      ilk_ms = 16'h0000;
  logic [7:0]       blk = 8'h03;
  logic             win_clr = 1'b0;
  logic [4:0]       leds;
  logic [4:0]       held;
  logic [4:0]       unk;
  logic [4:0][15:0] lit_cnt;
  logic [4:0][15:0] run_max;
  int               n_fail = 0;
  int               checks_done = 0;

  // {inputs, classes g r run err link}; 0 dark 1 lit 2 blink 3 flash
  // 4 double flash 5 flicker 6 toggling 7 three-pulse alarm group
  logic [32:0] rows [7] = '{
    {13'h0000, 20'h00000},
    {13'h1036, 20'h10121},
    {13'h181B, 20'h07235},
    {13'h122C, 20'h44340},
    {13'h1130, 20'h44100},
    {13'h1280, 20'h11000},
    {13'h1EC0, 20'h07000}
  };
  logic [1:0]  sq [5] = '{2'h2, 2'h1, 2'h3, 2'h0, 2'h2};

  always #4 mclk = ~mclk;

  drive_status_led_encoder #(.MS_CYCLES(MS)) u_drive_status_led_encoder (
    .mclk(mclk), .rst_n(rst_n), .ce(ce),
    .ctrl_power_ok(st[12]), .alarm_active(st[11]),
    .alarm_blinks(blk), .removal_active(st[10]),
    .removal_clear_input(clr_in), .info_active(st[9]),
    .remote_active(st[8]), .ilock_release(ilk), .ilock_ms(ilk_ms),
    .preset_exec(st[7]), .sim_mode(st[6]),
    .fb_state(fb_state_t'(st[5:4])), .comm_err(comm_err_t'(st[3:2])),
    .link_up(st[1]), .link_traffic(st[0]),
    .pa_green_r(leds[4]), .pa_red_r(leds[3]), .run_led_r(leds[2]),
    .err_led_r(leds[1]), .link_led_r(leds[0])
  );

  panel_viewer u_panel_viewer (
    .mclk(mclk), .clr(win_clr), .leds(leds),
    .lit_cnt(lit_cnt), .run_max(run_max), .unk(unk)
  );

  task automatic test_done();
    if (n_fail == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [4:0] e,
                     input logic [4:0] s);
    checks_done++;
    if (s !== e)
    begin
      $display("ERROR %s expected %h seen %h", nm, e, s);
      n_fail++;
    end
  endtask

  function automatic bit near(input int v, input int t);
    return v >= t - 16 && v <= t + 16;
  endfunction

  task automatic look(input int w);
    @(negedge mclk);
    win_clr = 1'b1;
    @(negedge mclk);
    win_clr = 1'b0;
    repeat (w) @(posedge mclk);
    #1;
  endtask

  task automatic see(input int i, input int c, input int w);
    int l;
    int m;
    bit ok;
    l = lit_cnt[i];
    m = run_max[i];
    case (c)
      0: ok = l == 0;
      1: ok = l == w;
      2: ok = near(l, w / 2) && near(m, ON);
      3: ok = near(l, 2 * ON) && near(m, ON);
      4: ok = l >= 2 * ON - 16 && l <= 4 * ON + 16 && near(m, ON);
      5: ok = near(l, w / 2) && near(m, `FLICK_MS * MS);
      6: ok = l > 0 && l < w;
      default: ok = near(l, 3 * ON) && near(m, ON);
    endcase
    checks_done++;
    if (!ok || unk[i] !== 1'b0)
    begin
      $display("ERROR led%0d expected class %0d seen lit %0d run %0d",
               i, c, l, m);
      n_fail++;
    end
  endtask

  initial
  begin
    repeat (6) @(posedge mclk);
    #1;
    cmp("outputs in reset", 5'h00, leds);
    @(negedge mclk);
    rst_n = 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    cmp("green before sync", 5'h00, leds);
    @(posedge mclk);
    #1;
    cmp("green after sync", 5'h10, leds);
    @(negedge mclk);
    st = 13'h1800;
    repeat (40) @(posedge mclk);
    @(negedge mclk);
    st = 13'h1000;
    @(posedge mclk);
    #1;
    cmp("green one edge", 5'h00, {4'h0, leds[4]});
    @(posedge mclk);
    #1;
    cmp("green two edges", 5'h02, {3'h0, leds[4:3]});
    foreach (rows[k])
    begin
      @(negedge mclk);
      st = rows[k][32:20];
      repeat (8) @(posedge mclk);
      look(W);
      for (int i = 0; i < 5; i++)
        see(i, int'(rows[k][4 * i +: 4]), W);
    end
    // clear while removal still active must be ignored
    @(negedge mclk);
    st = 13'h1400;
    clr_in = 1'b1;
    repeat (8) @(posedge mclk);
    look(4 * ON);
    see(4, 2, 4 * ON);
    see(3, 0, 4 * ON);
    @(negedge mclk);
    st = 13'h1000;
    clr_in = 1'b0;
    look(4 * ON);
    see(4, 2, 4 * ON);
    @(negedge mclk);
    clr_in = 1'b1;
    @(negedge mclk);
    clr_in = 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    cmp("green after clear", 5'h02, {3'h0, leds[4:3]});
    look(400);
    see(4, 1, 400);
    @(negedge mclk);
    ilk_ms = 16'h012C;
    ilk = 1'b1;
    @(negedge mclk);
    ilk = 1'b0;
    look(5 * ON);
    see(4, 6, 5 * ON);
    see(3, 6, 5 * ON);
    repeat (16'h012C * MS - 5 * ON + 40) @(posedge mclk);
    look(400);
    see(4, 1, 400);
    see(3, 0, 400);
    @(negedge mclk);
    ilk_ms = 16'h0000;
    ilk = 1'b1;
    @(negedge mclk);
    ilk = 1'b0;
    look(400);
    see(3, 0, 400);
    // two-pulse alarm group, entered fresh so it opens with a pulse
    @(negedge mclk);
    st = 13'h1800;
    blk = 8'h02;
    repeat (2) @(posedge mclk);
    look(4 * ON);
    see(3, 3, 4 * ON);
    see(4, 0, 4 * ON);
    @(negedge mclk);
    st = 13'h1040;
    repeat (2 + STEP / 2) @(posedge mclk);
    #1;
    for (int j = 0; j < 5; j++)
    begin
      cmp("sim step", {3'h0, sq[j]}, {3'h0, leds[4:3]});
      repeat (STEP) @(posedge mclk);
      #1;
    end
    // low enable must freeze every pattern
    @(negedge mclk);
    ce = 1'b0;
    held = leds;
    repeat (3000) @(posedge mclk);
    #1;
    cmp("frozen outputs", held, leds);
    test_done();
  end

  initial
  begin
    repeat (99000) @(posedge mclk);
    n_fail++;
    test_done();
  end
endmodule
